// ===== hw/odt_map.svh
// Purpose: constant map for the opcode decode and timing block
// Assumes: one-byte opcodes, 3-bit register and condition fields
// Notes: state counts are clock states of the processor
`ifndef ODT_MAP_SVH
`define ODT_MAP_SVH
`define ODT_REG_MEM 3'h6
`define ODT_REG_A 3'h7
`define ODT_ST_4 5'h04
`define ODT_ST_5 5'h05
`define ODT_ST_7 5'h07
`define ODT_ST_10 5'h0a
`define ODT_ST_11 5'h0b
`define ODT_ST_13 5'h0d
`define ODT_ST_16 5'h10
`define ODT_ST_17 5'h11
`define ODT_ST_18 5'h12
`define ODT_SP_STEP 16'h0002
`define ODT_OP_SUB_IMM 8'hd6
`define ODT_OP_RAL 8'h17
`define ODT_OP_SWAP_STACK_TOP_HL_OP 8'he3
`define ODT_OP_JUMP_VIA_HL_OP 8'he9
`define ODT_OP_SP_FROM_HL_OP 8'hf9
`define ODT_OP_SWAP_DE_HL_OP 8'heb
`define ODT_OP_DAD_SP 8'h39
`define ODT_OP_RET 8'hc9
`define ODT_OP_HALT 8'h76
`define ODT_OP_CMP_MEM 8'hbe
`define ODT_OP_XOR_MEM 8'hae
`define ODT_FLG_S 2'h3
`define ODT_FLG_Z 2'h2
`define ODT_FLG_P 2'h1
`define ODT_FLG_C 2'h0
`endif

// ===== hw/odt_pkg.sv
// Purpose: types for the opcode decode and timing block
// Assumes: codes are written out here; the map is not included
// Notes: class codes are the decoder's own
package odt_pkg;
    typedef enum logic [4:0] {
        ODT_CL_NOP = 5'h00, ODT_CL_COPY = 5'h01, ODT_CL_COPY_TO_MEM = 5'h02,
        ODT_CL_COPY_FROM_MEM = 5'h03, ODT_CL_ALU_REG = 5'h04, ODT_CL_ALU_MEM = 5'h05,
        ODT_CL_ALU_IMM = 5'h06, ODT_CL_ROTATE = 5'h07, ODT_CL_RET_COND = 5'h08,
        ODT_CL_RET = 5'h09, ODT_CL_LOAD_PAIR = 5'h0a, ODT_CL_PUSH = 5'h0b,
        ODT_CL_POP = 5'h0c, ODT_CL_SWAP_STACK = 5'h0d, ODT_CL_JUMP_HL = 5'h0e,
        ODT_CL_SP_HL = 5'h0f, ODT_CL_DOUBLE_ADD = 5'h10, ODT_CL_PAIR_INC = 5'h11,
        ODT_CL_SWAP_DE_HL = 5'h12, ODT_CL_OTHER = 5'h13
    } odt_class_t;
    typedef enum logic [1:0] {
        ODT_IDLE = 2'b00, ODT_DECODED = 2'b01, ODT_RESOLVED = 2'b11
    } odt_state_t;
endpackage : odt_pkg

// ===== hw/odt_cond_eval.sv
// Purpose: evaluates the three-bit condition field against the flags
// Assumes: flags are s, z, p, cy at positions from the map
// Notes: combinational; the parent registers the result
`include "odt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module odt_cond_eval (
    // field and flags
    input wire logic [2:0] cond_field,
    input wire logic [3:0] flags,
    // outcome
    output logic met
);
    logic sel;
    always_comb begin
        // see RULE19
        unique case (cond_field[2:1])
            2'b00: sel = flags[`ODT_FLG_Z];
            2'b01: sel = flags[`ODT_FLG_C];
            2'b10: sel = flags[`ODT_FLG_P];
            2'b11: sel = flags[`ODT_FLG_S];
        endcase
        met = cond_field[0] ? sel : ~sel; // see RULE19
    end
endmodule : odt_cond_eval
`default_nettype wire

// ===== hw/odt_reg_field.sv
// Purpose: splits a three-bit register field into a register index and memory flag
// Assumes: code 110 selects the byte addressed by hl
// Notes: combinational
`include "odt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module odt_reg_field (
    // field
    input wire logic [2:0] field,
    // decoded
    output logic is_mem,
    output logic [2:0] reg_index
);
    assign is_mem = (field == `ODT_REG_MEM); // see RULE1
    assign reg_index = field; // see RULE1
endmodule : odt_reg_field
`default_nettype wire

// ===== hw/odt_decode.sv
// Purpose: decodes a fetched opcode into class, operands and clock-state count
// Assumes: opcode and flags are valid with op_valid; all inputs synchronous to ref_clk
// Notes: result appears one edge after op_valid; the count is resolved from the flags in the same step
`include "odt_map.svh"
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: register codes B C D E H L M A
// RULE2: register copy takes five states
// RULE3: copy register to memory, seven states
// RULE4: copy memory to register, seven states
// RULE5: add with carry register, four states
// RULE6: xor register four, memory seven
// RULE7: compare memory sets flags, seven states
// RULE8: subtract immediate fetches byte, seven states
// RULE9: rotate through carry, four states
// RULE10: conditional return takes five or eleven
// RULE11: flag-dependent counts chosen by test
// RULE12: load pair immediate, ten states
// RULE13: push eleven, pop ten states
// RULE14: swap stack top with hl, eighteen
// RULE15: jump or sp from hl, five
// RULE16: double add sp into hl, ten
// RULE17: pair increment takes five states
// RULE18: swap de and hl, four states
// RULE19: condition codes nz z nc c po pe p m
// RULE20: pop reads sp, sp+1, sp up two
// RULE21: push writes sp-1, sp-2, sp down two
// RULE22: false condition short, true performs return
// RULE23: register code 110 means memory via hl
module odt_decode
    import odt_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // opcode from fetch
    input wire logic op_valid,
    input wire logic [7:0] opcode,
    input wire logic [3:0] flags,
    // decoded instruction
    output logic dec_valid,
    output logic [4:0] op_class,
    output logic [2:0] dest_reg_field,
    output logic [2:0] src_reg_field,
    output logic [2:0] cond_field,
    output logic [1:0] pair_sel,
    output logic [2:0] alu_sel,
    output logic cond_met,
    output logic [4:0] state_count,
    // memory and stack controls
    output logic mem_read_hl,
    output logic mem_write_hl,
    output logic fetch_imm,
    output logic [1:0] imm_bytes,
    output logic stack_read,
    output logic stack_write,
    output logic [15:0] sp_delta,
    output logic take_branch
);
    typedef struct packed {
        odt_state_t st;
        logic valid;
        odt_class_t cls;
        logic [2:0] dst;
        logic [2:0] src;
        logic [2:0] cnd;
        logic [1:0] rp;
        logic [2:0] alu;
        logic met;
        logic [4:0] cnt;
        logic mrd;
        logic mwr;
        logic imm;
        logic [1:0] nimm;
        logic srd;
        logic swr;
        logic [15:0] spd;
        logic br;
    } odt_state_pack_t;

    odt_state_pack_t q;
    odt_state_pack_t next_q;
    logic dst_mem;
    logic src_mem;
    logic met_now;

    odt_reg_field u_dst (
        .field(opcode[5:3]),
        .is_mem(dst_mem),
        .reg_index()
    );
    odt_reg_field u_src (
        .field(opcode[2:0]),
        .is_mem(src_mem),
        .reg_index()
    );
    odt_cond_eval u_cond (
        .cond_field(opcode[5:3]),
        .flags(flags),
        .met(met_now)
    );

    always_comb begin
        next_q = q;
        next_q.valid = 1'b0;
        if (op_valid) begin
            next_q.st = ODT_DECODED;
            next_q.valid = 1'b1;
            next_q.dst = opcode[5:3];
            next_q.src = opcode[2:0];
            next_q.cnd = opcode[5:3];
            next_q.rp = opcode[5:4];
            next_q.alu = opcode[5:3];
            next_q.met = 1'b0;
            next_q.cls = ODT_CL_OTHER;
            next_q.cnt = `ODT_ST_4;
            next_q.mrd = 1'b0;
            next_q.mwr = 1'b0;
            next_q.imm = 1'b0;
            next_q.nimm = 2'd0;
            next_q.srd = 1'b0;
            next_q.swr = 1'b0;
            next_q.spd = '0;
            next_q.br = 1'b0;
            unique case (opcode[7:6])
                2'b01: begin
                    if (opcode == `ODT_OP_HALT) begin
                        next_q.cls = ODT_CL_OTHER;
                        next_q.cnt = `ODT_ST_7;
                    end else if (dst_mem) begin
                        next_q.cls = ODT_CL_COPY_TO_MEM;
                        next_q.cnt = `ODT_ST_7; // see RULE3
                        next_q.mwr = 1'b1; // see RULE23
                    end else if (src_mem) begin
                        next_q.cls = ODT_CL_COPY_FROM_MEM;
                        next_q.cnt = `ODT_ST_7; // see RULE4
                        next_q.mrd = 1'b1; // see RULE23
                    end else begin
                        next_q.cls = ODT_CL_COPY;
                        next_q.cnt = `ODT_ST_5; // see RULE2
                    end
                end
                2'b10: begin
                    // alu group: add/adc/sub/sbb/and/xor/or/compare
                    if (src_mem) begin
                        next_q.cls = ODT_CL_ALU_MEM;
                        next_q.cnt = `ODT_ST_7; // see RULE6
                        next_q.mrd = 1'b1; // see RULE7
                    end else begin
                        next_q.cls = ODT_CL_ALU_REG;
                        next_q.cnt = `ODT_ST_4; // see RULE5
                    end
                end
                2'b00: begin
                    unique case (opcode[2:0])
                        3'b001: begin
                            if (opcode[3]) begin
                                next_q.cls = ODT_CL_DOUBLE_ADD;
                                next_q.cnt = `ODT_ST_10; // see RULE16
                            end else begin
                                next_q.cls = ODT_CL_LOAD_PAIR;
                                next_q.cnt = `ODT_ST_10; // see RULE12
                                next_q.imm = 1'b1;
                                next_q.nimm = 2'd2;
                            end
                        end
                        3'b011: begin
                            next_q.cls = opcode[3] ? ODT_CL_OTHER : ODT_CL_PAIR_INC;
                            next_q.cnt = `ODT_ST_5; // see RULE17
                        end
                        3'b100, 3'b101: begin
                            next_q.cls = ODT_CL_OTHER;
                            next_q.cnt = dst_mem ? `ODT_ST_10 : `ODT_ST_5;
                            next_q.mrd = dst_mem; // see RULE23
                            next_q.mwr = dst_mem;
                        end
                        3'b110: begin
                            next_q.cls = ODT_CL_OTHER;
                            next_q.cnt = dst_mem ? `ODT_ST_10 : `ODT_ST_7;
                            next_q.mwr = dst_mem; // see RULE23
                            next_q.imm = 1'b1;
                            next_q.nimm = 2'd1;
                        end
                        3'b111: begin
                            next_q.cls = (opcode == `ODT_OP_RAL) ? ODT_CL_ROTATE : ODT_CL_OTHER;
                            next_q.cnt = `ODT_ST_4; // see RULE9
                        end
                        3'b010: begin
                            next_q.cls = ODT_CL_OTHER;
                            next_q.cnt = opcode[5] ? (opcode[4] ? `ODT_ST_13 : `ODT_ST_16) : `ODT_ST_7;
                        end
                        default: begin
                            next_q.cls = ODT_CL_NOP;
                            next_q.cnt = `ODT_ST_4;
                        end
                    endcase
                end
                2'b11: begin
                    unique case (opcode[2:0])
                        3'b000: begin
                            next_q.cls = ODT_CL_RET_COND;
                            next_q.met = met_now; // see RULE11
                            // short count falls through, long count pops the return address
                            next_q.cnt = met_now ? `ODT_ST_11 : `ODT_ST_5; // see RULE10
                            next_q.srd = met_now; // see RULE22
                            next_q.br = met_now; // see RULE22
                            next_q.spd = met_now ? `ODT_SP_STEP : 16'h0000; // see RULE20
                        end
                        3'b001: begin
                            if (opcode == `ODT_OP_RET) begin
                                next_q.cls = ODT_CL_RET;
                                next_q.cnt = `ODT_ST_10;
                                next_q.srd = 1'b1;
                                next_q.br = 1'b1;
                                next_q.spd = `ODT_SP_STEP; // see RULE20
                            end else if (opcode == `ODT_OP_JUMP_VIA_HL_OP) begin
                                next_q.cls = ODT_CL_JUMP_HL;
                                next_q.cnt = `ODT_ST_5; // see RULE15
                                next_q.br = 1'b1;
                            end else if (opcode == `ODT_OP_SP_FROM_HL_OP) begin
                                next_q.cls = ODT_CL_SP_HL;
                                next_q.cnt = `ODT_ST_5; // see RULE15
                            end else begin
                                next_q.cls = ODT_CL_POP;
                                next_q.cnt = `ODT_ST_10; // see RULE13
                                next_q.srd = 1'b1;
                                next_q.spd = `ODT_SP_STEP; // see RULE20
                            end
                        end
                        3'b101: begin
                            if (opcode[3]) begin
                                // unconditional call; conditional jump/call timing not decoded here
                                next_q.cls = ODT_CL_OTHER;
                                next_q.cnt = `ODT_ST_17;
                            end else begin
                                next_q.cls = ODT_CL_PUSH;
                                next_q.cnt = `ODT_ST_11; // see RULE13
                                next_q.swr = 1'b1;
                                next_q.spd = 16'h0000 - `ODT_SP_STEP; // see RULE21
                            end
                        end
                        3'b011: begin
                            if (opcode == `ODT_OP_SWAP_STACK_TOP_HL_OP) begin
                                next_q.cls = ODT_CL_SWAP_STACK;
                                next_q.cnt = `ODT_ST_18; // see RULE14
                                next_q.srd = 1'b1;
                                next_q.swr = 1'b1;
                            end else if (opcode == `ODT_OP_SWAP_DE_HL_OP) begin
                                next_q.cls = ODT_CL_SWAP_DE_HL;
                                next_q.cnt = `ODT_ST_4; // see RULE18
                            end else begin
                                next_q.cls = ODT_CL_OTHER;
                                next_q.cnt = opcode[4] ? `ODT_ST_10 : `ODT_ST_4;
                            end
                        end
                        3'b110: begin
                            next_q.cls = ODT_CL_ALU_IMM;
                            next_q.cnt = `ODT_ST_7; // see RULE8
                            next_q.imm = 1'b1; // see RULE8
                            next_q.nimm = 2'd1;
                        end
                        3'b111: begin
                            next_q.cls = ODT_CL_OTHER;
                            next_q.cnt = `ODT_ST_11;
                            next_q.swr = 1'b1;
                            next_q.br = 1'b1;
                            next_q.spd = 16'h0000 - `ODT_SP_STEP; // see RULE21
                        end
                        default: begin
                            next_q.cls = ODT_CL_OTHER;
                            next_q.cnt = `ODT_ST_10;
                        end
                    endcase
                end
            endcase
            if (next_q.cls == ODT_CL_RET_COND) begin
                next_q.st = ODT_RESOLVED;
            end
        end else begin
            next_q.st = ODT_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            q <= '0;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

    assign dec_valid = q.valid;
    assign op_class = q.cls;
    assign dest_reg_field = q.dst;
    assign src_reg_field = q.src;
    assign cond_field = q.cnd;
    assign pair_sel = q.rp;
    assign alu_sel = q.alu;
    assign cond_met = q.met;
    assign state_count = q.cnt;
    assign mem_read_hl = q.mrd;
    assign mem_write_hl = q.mwr;
    assign fetch_imm = q.imm;
    assign imm_bytes = q.nimm;
    assign stack_read = q.srd;
    assign stack_write = q.swr;
    assign sp_delta = q.spd;
    assign take_branch = q.br;
endmodule : odt_decode
`default_nettype wire

// ===== tb/odt_decode_checker.sv
// Purpose: port-level assertions for the opcode decode and timing block
// Assumes: all signals on ref_clk, synchronous active-low rstn
// Notes: attached to odt_decode by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module odt_decode_checker
    import odt_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // request
    input wire logic op_valid,
    input wire logic [7:0] opcode,
    input wire logic [3:0] flags,
    // decoded
    input wire logic dec_valid,
    input wire logic [4:0] op_class,
    input wire logic [2:0] dest_reg_field,
    input wire logic [2:0] src_reg_field,
    input wire logic cond_met,
    input wire logic [4:0] state_count,
    input wire logic mem_read_hl,
    input wire logic mem_write_hl,
    input wire logic stack_read,
    input wire logic stack_write,
    input wire logic [15:0] sp_delta,
    input wire logic take_branch
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic take;
    assign take = op_valid && clk_en;
    // condition outcome worked out here from the flags, so a wrong flag select in the design is caught
    logic exp_flag;
    logic exp_met;
    always_comb begin
        unique case (opcode[5:4])
            2'b00: exp_flag = flags[2];
            2'b01: exp_flag = flags[0];
            2'b10: exp_flag = flags[1];
            2'b11: exp_flag = flags[3];
        endcase
    end
    assign exp_met = (exp_flag == opcode[3]);

    a_answer_next_edge: assert property (take |=> dec_valid && src_reg_field == $past(opcode[2:0]))
        else $error("decode result missing one edge after request");
    a_copy_five_states: assert property (take && opcode[7:6] == 2'b01 && opcode[5:3] != 3'h6 && opcode[2:0] != 3'h6
        |=> state_count == 5'h05 && !mem_read_hl && !mem_write_hl)
        else $error("register copy count wrong");
    a_mem_dest_write: assert property (take && opcode[7:3] == 5'b01110 && opcode[2:0] != 3'h6
        |=> mem_write_hl && !mem_read_hl && state_count == 5'h07)
        else $error("copy to memory wrong");
    a_mem_src_read: assert property (take && opcode[7:6] == 2'b01 && opcode[5:3] != 3'h6 && opcode[2:0] == 3'h6
        |=> mem_read_hl && dest_reg_field == $past(opcode[5:3]) && state_count == 5'h07)
        else $error("copy from memory wrong");
    a_alu_reg_four: assert property (take && (opcode[7:3] == 5'b10001 || opcode[7:3] == 5'b10101)
        && opcode[2:0] != 3'h6 |=> state_count == 5'h04)
        else $error("alu register count wrong");
    a_cond_ret_count: assert property (take && opcode[7:6] == 2'b11 && opcode[2:0] == 3'h0
        |=> cond_met == $past(exp_met) && state_count == (cond_met ? 5'h0b : 5'h05))
        else $error("conditional return count wrong");
    a_ret_taken_stack: assert property (dec_valid && op_class == ODT_CL_RET_COND && cond_met
        |-> stack_read && take_branch && sp_delta == 16'h0002)
        else $error("taken return lacks stack pop");
    a_push_down_two: assert property (take && opcode[7:6] == 2'b11 && opcode[3:0] == 4'h5
        |=> stack_write && sp_delta == 16'hfffe && state_count == 5'h0b)
        else $error("push controls wrong");
    a_freeze_hold: assert property (!clk_en |=> $stable(state_count) && $stable(dec_valid))
        else $error("outputs moved while frozen");

    c_swap_stack: cover property (take && opcode == 8'he3);
    c_ret_taken: cover property (dec_valid && op_class == ODT_CL_RET_COND && cond_met);
    c_ret_skipped: cover property (dec_valid && op_class == ODT_CL_RET_COND && !cond_met);
    c_frozen: cover property (!clk_en ##1 !clk_en);
endmodule : odt_decode_checker

bind odt_decode odt_decode_checker u_chk (.ref_clk, .rstn, .clk_en, .op_valid, .opcode, .flags, .dec_valid, .op_class,
    .dest_reg_field, .src_reg_field, .cond_met, .state_count, .mem_read_hl, .mem_write_hl, .stack_read,
    .stack_write, .sp_delta, .take_branch);
`default_nettype wire

// ===== tb/odt_decode_tb.sv
// Purpose: self-checking bench for the opcode decode and timing block
// Assumes: result one edge after op_valid, fields hold otherwise
// Notes: opcodes outside the modelled set are sent only with op_valid low
`timescale 1ns/1ps
`default_nettype none
module odt_decode_tb
    import odt_pkg::*;
    ;
    logic ref_clk, rstn, clk_en, op_valid;
    logic [7:0] opcode;
    logic [3:0] flags;
    logic dec_valid, cond_met, mem_read_hl, mem_write_hl, fetch_imm, stack_read, stack_write, take_branch;
    logic [4:0] op_class, state_count;
    logic [2:0] dest_reg_field, src_reg_field, cond_field, alu_sel;
    logic [1:0] pair_sel, imm_bytes;
    logic [15:0] sp_delta;
    logic [15:0] e_cnt, e_rd, e_wr, e_imm, e_sr, e_sw, e_dlt, e_met, e_br, last_cnt;
    bit pv;
    odt_class_t e_cls;
    logic [7:0] p_op;
    logic [3:0] p_fl;
    logic [7:0] ops[$];
    int failures, checks_done;

    odt_decode dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .op_valid(op_valid), .opcode(opcode),
        .flags(flags), .dec_valid(dec_valid), .op_class(op_class), .dest_reg_field(dest_reg_field),
        .src_reg_field(src_reg_field), .cond_field(cond_field), .pair_sel(pair_sel), .alu_sel(alu_sel),
        .cond_met(cond_met), .state_count(state_count), .mem_read_hl(mem_read_hl), .mem_write_hl(mem_write_hl),
        .fetch_imm(fetch_imm), .imm_bytes(imm_bytes), .stack_read(stack_read), .stack_write(stack_write),
        .sp_delta(sp_delta), .take_branch(take_branch));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // reference model; e_cnt of all ones marks an opcode left out
    function automatic void model(input logic [7:0] op, input logic [3:0] fl);
        logic f;
        {e_rd, e_wr, e_imm, e_sr, e_sw, e_dlt, e_met, e_br} = '0;
        e_cnt = 16'hffff;
        e_cls = ODT_CL_OTHER;
        case (op[5:4])
            2'h0: f = fl[2];
            2'h1: f = fl[0];
            2'h2: f = fl[1];
            default: f = fl[3];
        endcase
        if (op[7:6] == 2'b01 && op != 8'h76) begin
            e_cnt = (op[5:3] == 3'h6 || op[2:0] == 3'h6) ? 16'h0007 : 16'h0005;
            e_wr = {15'h0, op[5:3] == 3'h6};
            e_rd = {15'h0, op[2:0] == 3'h6};
            e_cls = (op[5:3] == 3'h6) ? ODT_CL_COPY_TO_MEM : (op[2:0] == 3'h6) ? ODT_CL_COPY_FROM_MEM : ODT_CL_COPY;
        end else if (op[7:3] == 5'b10001 || op[7:3] == 5'b10101 || op == 8'hbe) begin
            e_cnt = (op[2:0] == 3'h6) ? 16'h0007 : 16'h0004;
            e_rd = {15'h0, op[2:0] == 3'h6};
            e_cls = (op[2:0] == 3'h6) ? ODT_CL_ALU_MEM : ODT_CL_ALU_REG;
        end else if (op == 8'hd6) begin
            e_cnt = 16'h0007;
            e_imm = 16'h0001;
            e_cls = ODT_CL_ALU_IMM;
        end else if (op[7:6] == 2'b11 && op[2:0] == 3'h0) begin
            e_cls = ODT_CL_RET_COND;
            e_met = {15'h0, f == op[3]};
            e_cnt = e_met[0] ? 16'h000b : 16'h0005;
            e_sr = e_met;
            e_br = e_met;
            e_dlt = e_met[0] ? 16'h0002 : 16'h0000;
        end else if (op[7:6] == 2'b00 && op[3:0] == 4'h1) begin
            e_cnt = 16'h000a;
            e_imm = 16'h0002;
            e_cls = ODT_CL_LOAD_PAIR;
        end else if (op[7:6] == 2'b11 && op[3:0] == 4'h5) begin
            e_cls = ODT_CL_PUSH;
            e_cnt = 16'h000b;
            e_sw = 16'h0001;
            e_dlt = 16'hfffe;
        end else if (op[7:6] == 2'b11 && op[3:0] == 4'h1) begin
            e_cls = ODT_CL_POP;
            e_cnt = 16'h000a;
            e_sr = 16'h0001;
            e_dlt = 16'h0002;
        end else if (op[7:6] == 2'b00 && op[3:0] == 4'h3) begin
            e_cnt = 16'h0005;
            e_cls = ODT_CL_PAIR_INC;
        end else begin
            case (op)
                8'h17: e_cnt = 16'h0004;
                8'he3: e_cnt = 16'h0012;
                8'he9: e_cnt = 16'h0005;
                8'hf9: e_cnt = 16'h0005;
                8'h39: e_cnt = 16'h000a;
                8'heb: e_cnt = 16'h0004;
                default: e_cnt = 16'hffff;
            endcase
            case (op)
                8'h17: e_cls = ODT_CL_ROTATE;
                8'he3: e_cls = ODT_CL_SWAP_STACK;
                8'he9: e_cls = ODT_CL_JUMP_HL;
                8'hf9: e_cls = ODT_CL_SP_HL;
                8'h39: e_cls = ODT_CL_DOUBLE_ADD;
                8'heb: e_cls = ODT_CL_SWAP_DE_HL;
                default: e_cls = ODT_CL_OTHER;
            endcase
            e_br = {15'h0, op == 8'he9};
            // stack-top swap reads and writes the stack but leaves the pointer where it was
            e_sr = {15'h0, op == 8'he3};
            e_sw = e_sr;
        end
    endfunction : model

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic check_prev();
        model(p_op, p_fl);
        last_cnt = e_cnt;
        chk("state_count", e_cnt, {11'h0, state_count});
        chk("dest_field", {13'h0, p_op[5:3]}, {13'h0, dest_reg_field});
        chk("src_field", {13'h0, p_op[2:0]}, {13'h0, src_reg_field});
        chk("cond_field", {13'h0, p_op[5:3]}, {13'h0, cond_field});
        chk("pair_sel", {14'h0, p_op[5:4]}, {14'h0, pair_sel});
        chk("alu_sel", {13'h0, p_op[5:3]}, {13'h0, alu_sel});
        chk("op_class", {11'h0, e_cls}, {11'h0, op_class});
        chk("mem_read", e_rd, {15'h0, mem_read_hl});
        chk("mem_write", e_wr, {15'h0, mem_write_hl});
        chk("imm_bytes", e_imm, {14'h0, imm_bytes});
        chk("fetch_imm", {15'h0, e_imm != 16'h0}, {15'h0, fetch_imm});
        chk("stack_read", e_sr, {15'h0, stack_read});
        chk("stack_write", e_sw, {15'h0, stack_write});
        chk("sp_delta", e_dlt, sp_delta);
        chk("cond_met", e_met, {15'h0, cond_met});
        chk("take_branch", e_br, {15'h0, take_branch});
    endtask : check_prev

    // results of the previous request are judged one step after the edge that launched this one
    task automatic send(input logic [7:0] op, input logic [3:0] fl, input bit v);
        @(posedge ref_clk);
        op_valid <= v;
        opcode <= op;
        flags <= fl;
        #1;
        chk("dec_valid", {15'h0, pv}, {15'h0, dec_valid});
        if (pv) check_prev();
        else chk("held_count", last_cnt, {11'h0, state_count});
        pv = v;
        p_op = op;
        p_fl = fl;
    endtask : send

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    initial begin
        #200_000;
        failures++;
        give_verdict();
    end

    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        op_valid = 1'b0;
        opcode = 8'h00;
        flags = 4'h0;
        failures = 0;
        checks_done = 0;
        pv = 1'b0;
        last_cnt = 16'h0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        void'($urandom(32'hd247));
        for (int i = 0; i < 256; i++) begin
            model(i[7:0], 4'h0);
            if (e_cnt != 16'hffff) ops.push_back(i[7:0]);
        end
        foreach (ops[i]) send(ops[i], 4'($urandom), 1'b1);
        // every condition code with its flag both clear and set
        for (int c = 0; c < 8; c++) begin
            send({2'b11, c[2:0], 3'h0}, 4'h0, 1'b1);
            send({2'b11, c[2:0], 3'h0}, 4'hf, 1'b1);
        end
        repeat (300) send(ops[$urandom % ops.size()], 4'($urandom), ($urandom % 4) != 0);
        send(8'he3, 4'h0, 1'b1);
        send(8'h41, 4'h0, 1'b0);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        op_valid <= 1'b1;
        opcode <= 8'h17;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("frozen_count", 16'h0012, {11'h0, state_count});
        @(posedge ref_clk);
        clk_en <= 1'b1;
        op_valid <= 1'b0;
        send(8'h00, 4'h0, 1'b0);
        send(8'h00, 4'h0, 1'b0);
        give_verdict();
    end
endmodule : odt_decode_tb
`default_nettype wire
